// ---- logic/rtc_pkg.sv ----
// Constants, bus carrier and state layout of the BCD clock calendar.
// Assumes one 125 MHz system clock; the host bus pins are asynchronous.
`default_nettype none
package rtc_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_HZ = 10;
   localparam int PRE_W = 24;
   localparam int ICNT_W = 10;
   // ==========================================================
   // Register locations
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_TENTH = 4'h1;
   localparam logic [3:0] A_SEC_U = 4'h2;
   localparam logic [3:0] A_SEC_T = 4'h3;
   localparam logic [3:0] A_MIN_U = 4'h4;
   localparam logic [3:0] A_MIN_T = 4'h5;
   localparam logic [3:0] A_HR_U = 4'h6;
   localparam logic [3:0] A_HR_T = 4'h7;
   localparam logic [3:0] A_DAY_U = 4'h8;
   localparam logic [3:0] A_DAY_T = 4'h9;
   localparam logic [3:0] A_MON_U = 4'hA;
   localparam logic [3:0] A_MON_T = 4'hB;
   localparam logic [3:0] A_YR_U = 4'hC;
   localparam logic [3:0] A_YR_T = 4'hD;
   localparam logic [3:0] A_WDAY = 4'hE;
   localparam logic [3:0] A_SETUP = 4'hF;
   // ==========================================================
   // Field positions
   localparam int CTL_TEST = 3;
   localparam int CTL_CLK_STOP = 2;
   localparam int CTL_INT_SEL = 1;
   localparam int CTL_INT_STOP = 0;
   localparam int ST_DCHG = 3;
   localparam int ST_IFLAG = 0;
   localparam int CS_MODE24 = 0;
   localparam int CS_PM = 1;
   localparam int CS_LEAP_LO = 2;
   localparam int CS_LEAP_HI = 3;
   localparam int IR_REPEAT = 3;
   localparam int IR_CODE_W = 3;
   // ==========================================================
   // Digit limits and masks
   localparam logic [3:0] ZERO = 4'h0;
   localparam logic [3:0] FIRST = 4'h1;
   localparam logic [3:0] BCD_LAST = 4'h9;
   localparam logic [3:0] SIX_LAST = 4'h5;
   localparam logic [3:0] HR24_T_LAST = 4'h2;
   localparam logic [3:0] HR24_U_LAST = 4'h3;
   localparam logic [3:0] HR12_T = 4'h1;
   localparam logic [3:0] HR12_U_TOP = 4'h2;
   localparam logic [3:0] HR12_U_PRE = 4'h1;
   localparam logic [3:0] WDAY_LAST = 4'h7;
   localparam logic [7:0] MON_LAST = 8'h12;
   localparam logic [7:0] DAY_FIRST = 8'h01;
   localparam logic [3:0] HT12_MASK = 4'h1;
   localparam logic [3:0] HT24_MASK = 4'h3;
   localparam logic [3:0] CTL_RST = 4'h5;
   // ==========================================================
   // Carriers and state
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [3:0] addr;
      logic [3:0] data;
   } bus_in_t;
   localparam bus_in_t BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 4'h0};
   typedef struct packed {
      bus_in_t s1;
      bus_in_t s2;
      bus_in_t wcap;
      logic rs;
      logic ws;
      logic ctl_rd;
      logic [15:0][3:0] tm;
      logic [3:0] ctl;
      logic [3:0] setup;
      logic [3:0] irq;
      logic dchg;
      logic iflag;
      logic ipend;
      logic [PRE_W-1:0] pre;
      logic [PRE_W-1:0] ipre;
      logic [ICNT_W-1:0] icnt;
      logic [3:0] dout;
      logic oe;
      logic irq_n;
   } rtc_state_t;
   localparam rtc_state_t ST_RST = '{s1: BUS_IDLE, s2: BUS_IDLE, wcap: BUS_IDLE, ctl: CTL_RST,
                                     irq_n: 1'b1, default: '0};
   // ==========================================================
   // Interval period in tenths of a second.
   function automatic logic [ICNT_W-1:0] period(input logic [IR_CODE_W-1:0] code);
      case (code)
         3'h1: period = 10'h001;
         3'h2: period = 10'h005;
         3'h3: period = 10'h00A;
         3'h4: period = 10'h032;
         3'h5: period = 10'h064;
         3'h6: period = 10'h12C;
         3'h7: period = 10'h258;
         default: period = 10'h000;
      endcase
   endfunction
   // Last day of a BCD month.
   function automatic logic [7:0] month_days(input logic [7:0] mon, input logic leap);
      case (mon)
         8'h02: month_days = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         default: month_days = 8'h31;
      endcase
   endfunction
endpackage
`default_nettype wire

// ---- logic/rtc_core.sv ----
// BCD clock calendar with interval timer behind a 4-bit strobed bus.
// Assumes host pins are asynchronous and idle high; the bus is
// released when the read strobe ends.
//
// Behaviour
// (R1) Seconds digits writable, all seconds readable.
// (R2) 12-hour tens-of-hours reads one bit.
// (R3) 24-hour: two hour-tens bits, PM reads 0.
// (R4) Units of hours always four bits.
// (R5) Setup bit 0 picks 12 or 24 hours.
// (R6) PM toggles rolling 11:59 to 12:00.
// (R7) Day limit from month and leap count.
// (R8) Years count 00 to 99, read/write.
// (R9) Weekday 1 to 7 advances at midnight.
// (R10) Sixteen locations; 0 split, 1 read-only.
// (R11) Select bit routes location F; timing continues.
// (R12) Two-bit leap counter advances at new year.
// (R13) Host loads years since last leap year.
// (R14) Host writes hour mode, PM separately.
// (R15) Whole clock setup register is readable.
// (R16) Low three bits choose interval period.
// (R17) Bit 3 picks single or repeated interrupts.
// (R18) Code zero clears output, sets stop bit.
// (R19) Repeats stay locked to first timeout.
// (R20) Clock stop bit clears tenths counter.
// (R21) All time digits advance on tick.
// (R22) Control write bit 1 is select bit.
// (R23) Counters hold BCD digits.
// (R24) Timeout interrupts; single stops, repeated restarts.
// (R25) Months 01..12 carry into years, leap.
`timescale 1ns/1ps
`default_nettype none
module rtc_core #(
   parameter int unsigned TICK_CYCLES = rtc_pkg::CLK_HZ / rtc_pkg::TICK_HZ
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [3:0] register_select_lines,
   input wire logic [3:0] bus_data_lines_in,
   output logic [3:0] bus_data_lines_out,
   output logic bus_data_lines_oe,
   output logic irq_n
);
   // ==========================================================
   // State
   rtc_pkg::rtc_state_t st;
   rtc_pkg::rtc_state_t nx;
   rtc_pkg::bus_in_t pin;
   logic rs;
   logic ws;
   logic commit;
   logic rs_rise;
   logic rs_fall;
   logic tick;
   logic itick;
   logic irun;
   logic tmo;
   logic day_roll;
   logic mon_roll;

   // 4-bit BCD step: carry out and next digit.
   function automatic logic [4:0] bump(input logic [3:0] d, input logic [3:0] last);
      bump = (d == last) ? {1'b1, rtc_pkg::ZERO} : {1'b0, d + 4'h1};
   endfunction

   assign pin = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, addr: register_select_lines,
                  data: bus_data_lines_in};
   assign rs = !st.s2.cs_n && !st.s2.rd_n;
   assign ws = !st.s2.cs_n && !st.s2.wr_n;
   // Writes take effect when the write strobe ends, as on the pins.
   assign commit = st.ws && !ws;
   assign rs_rise = rs && !st.rs;
   assign rs_fall = st.rs && !rs;
   // (R21) Common tick
   assign tick = st.pre == rtc_pkg::PRE_W'(TICK_CYCLES - 1);
   // The interval prescaler restarts with the timer, so the first timeout is
   // not off by a part of a tick as it would be on the free-running one.
   // (R19) Phase from start
   assign itick = st.ipre == rtc_pkg::PRE_W'(TICK_CYCLES - 1);
   assign irun = !st.ctl[rtc_pkg::CTL_INT_STOP] && (st.irq[rtc_pkg::IR_CODE_W-1:0] != '0);
   // (R16) Period decode
   assign tmo = itick && irun &&
                (st.icnt == rtc_pkg::period(st.irq[rtc_pkg::IR_CODE_W-1:0]) - 10'h001);

   // ==========================================================
   // Next state
   always_comb begin
      logic c;
      logic [3:0] a;
      logic [3:0] d;
      c = 1'b0;
      a = st.wcap.addr;
      d = st.wcap.data;
      nx = st;
      day_roll = 1'b0;
      mon_roll = 1'b0;
      nx.s1 = pin;
      nx.s2 = st.s1;
      nx.rs = rs;
      nx.ws = ws;
      nx.oe = rs;
      if (ws) begin
         nx.wcap = st.s2;
      end
      nx.pre = tick ? '0 : st.pre + 1'b1;

      // (R21) Tick advance
      if (tick && !st.ctl[rtc_pkg::CTL_CLK_STOP]) begin
         // (R23) BCD carry chain
         {c, nx.tm[rtc_pkg::A_TENTH]} = bump(st.tm[rtc_pkg::A_TENTH], rtc_pkg::BCD_LAST);
         if (c) begin
            {c, nx.tm[rtc_pkg::A_SEC_U]} = bump(st.tm[rtc_pkg::A_SEC_U], rtc_pkg::BCD_LAST);
         end
         if (c) begin
            {c, nx.tm[rtc_pkg::A_SEC_T]} = bump(st.tm[rtc_pkg::A_SEC_T], rtc_pkg::SIX_LAST);
         end
         if (c) begin
            {c, nx.tm[rtc_pkg::A_MIN_U]} = bump(st.tm[rtc_pkg::A_MIN_U], rtc_pkg::BCD_LAST);
         end
         if (c) begin
            {c, nx.tm[rtc_pkg::A_MIN_T]} = bump(st.tm[rtc_pkg::A_MIN_T], rtc_pkg::SIX_LAST);
         end
         // (R5) Hour counting mode
         if (c && st.setup[rtc_pkg::CS_MODE24]) begin
            if (st.tm[rtc_pkg::A_HR_T] == rtc_pkg::HR24_T_LAST &&
                st.tm[rtc_pkg::A_HR_U] == rtc_pkg::HR24_U_LAST) begin
               nx.tm[rtc_pkg::A_HR_T] = rtc_pkg::ZERO;
               nx.tm[rtc_pkg::A_HR_U] = rtc_pkg::ZERO;
            end else begin
               {c, nx.tm[rtc_pkg::A_HR_U]} = bump(st.tm[rtc_pkg::A_HR_U], rtc_pkg::BCD_LAST);
               if (c) begin
                  nx.tm[rtc_pkg::A_HR_T] = st.tm[rtc_pkg::A_HR_T] + 4'h1;
               end
               c = 1'b0;
            end
         end else if (c) begin
            c = 1'b0;
            if (st.tm[rtc_pkg::A_HR_T] == rtc_pkg::HR12_T &&
                st.tm[rtc_pkg::A_HR_U] == rtc_pkg::HR12_U_TOP) begin
               nx.tm[rtc_pkg::A_HR_T] = rtc_pkg::ZERO;
               nx.tm[rtc_pkg::A_HR_U] = rtc_pkg::FIRST;
            end else if (st.tm[rtc_pkg::A_HR_T] == rtc_pkg::HR12_T &&
                         st.tm[rtc_pkg::A_HR_U] == rtc_pkg::HR12_U_PRE) begin
               nx.tm[rtc_pkg::A_HR_U] = rtc_pkg::HR12_U_TOP;
               // (R6) Noon and midnight flip
               nx.setup[rtc_pkg::CS_PM] = !st.setup[rtc_pkg::CS_PM];
               c = st.setup[rtc_pkg::CS_PM];
            end else begin
               {c, nx.tm[rtc_pkg::A_HR_U]} = bump(st.tm[rtc_pkg::A_HR_U], rtc_pkg::BCD_LAST);
               if (c) begin
                  nx.tm[rtc_pkg::A_HR_T] = rtc_pkg::HR12_T;
               end
               c = 1'b0;
            end
         end
         day_roll = c;
         if (c) begin
            // (R9) Weekday at midnight
            nx.tm[rtc_pkg::A_WDAY] = (st.tm[rtc_pkg::A_WDAY] == rtc_pkg::WDAY_LAST) ?
                                     rtc_pkg::FIRST : st.tm[rtc_pkg::A_WDAY] + 4'h1;
            // (R7) Month length limit
            if ({st.tm[rtc_pkg::A_DAY_T], st.tm[rtc_pkg::A_DAY_U]} ==
                rtc_pkg::month_days({st.tm[rtc_pkg::A_MON_T], st.tm[rtc_pkg::A_MON_U]},
                                    st.setup[rtc_pkg::CS_LEAP_HI:rtc_pkg::CS_LEAP_LO] == 2'h0)) begin
               {nx.tm[rtc_pkg::A_DAY_T], nx.tm[rtc_pkg::A_DAY_U]} = rtc_pkg::DAY_FIRST;
            end else begin
               {c, nx.tm[rtc_pkg::A_DAY_U]} = bump(st.tm[rtc_pkg::A_DAY_U], rtc_pkg::BCD_LAST);
               if (c) begin
                  nx.tm[rtc_pkg::A_DAY_T] = st.tm[rtc_pkg::A_DAY_T] + 4'h1;
               end
               c = 1'b0;
            end
         end
         if (c) begin
            // (R25) Month wrap
            if ({st.tm[rtc_pkg::A_MON_T], st.tm[rtc_pkg::A_MON_U]} == rtc_pkg::MON_LAST) begin
               {nx.tm[rtc_pkg::A_MON_T], nx.tm[rtc_pkg::A_MON_U]} = rtc_pkg::DAY_FIRST;
            end else begin
               {c, nx.tm[rtc_pkg::A_MON_U]} = bump(st.tm[rtc_pkg::A_MON_U], rtc_pkg::BCD_LAST);
               if (c) begin
                  nx.tm[rtc_pkg::A_MON_T] = st.tm[rtc_pkg::A_MON_T] + 4'h1;
               end
               c = 1'b0;
            end
         end
         mon_roll = c;
         if (c) begin
            // (R12) Leap counter step
            nx.setup[rtc_pkg::CS_LEAP_HI:rtc_pkg::CS_LEAP_LO] =
               st.setup[rtc_pkg::CS_LEAP_HI:rtc_pkg::CS_LEAP_LO] + 2'h1;
            // (R8) Years wrap 99 to 00
            {c, nx.tm[rtc_pkg::A_YR_U]} = bump(st.tm[rtc_pkg::A_YR_U], rtc_pkg::BCD_LAST);
            if (c) begin
               {c, nx.tm[rtc_pkg::A_YR_T]} = bump(st.tm[rtc_pkg::A_YR_T], rtc_pkg::BCD_LAST);
            end
         end
         // A tick inside a status read leaves the changed flag alone.
         if (!st.ctl_rd) begin
            nx.dchg = 1'b1;
         end
      end
      // (R20) Tenths held clear
      if (st.ctl[rtc_pkg::CTL_CLK_STOP]) begin
         nx.tm[rtc_pkg::A_TENTH] = rtc_pkg::ZERO;
      end

      // ==========================================================
      // Interval timer, counted in ticks so repeats never drift.
      // (R11) Timer independent of select
      if (!irun) begin
         nx.ipre = '0;
         nx.icnt = '0;
      end else begin
         nx.ipre = itick ? '0 : st.ipre + 1'b1;
         if (itick) begin
            // (R19) Restart from exact timeout
            nx.icnt = tmo ? '0 : st.icnt + 1'b1;
         end
      end
      if (tmo) begin
         // (R24) Timeout raises interrupt
         // A timeout at the very start of a status read is held back too,
         // or the end of that read would clear a flag that it never showed.
         if (st.ctl_rd || (rs_rise && st.s2.addr == rtc_pkg::A_CTRL)) begin
            nx.ipend = 1'b1;
         end else begin
            nx.iflag = 1'b1;
         end
         // (R17) Single mode halts
         if (!st.irq[rtc_pkg::IR_REPEAT]) begin
            nx.ctl[rtc_pkg::CTL_INT_STOP] = 1'b1;
         end
      end

      // ==========================================================
      // Read side: data is latched at strobe start and held.
      if (rs_rise) begin
         nx.ctl_rd = st.s2.addr == rtc_pkg::A_CTRL;
         // (R10) Read decode
         if (st.s2.addr == rtc_pkg::A_CTRL) begin
            nx.dout = '0;
            nx.dout[rtc_pkg::ST_DCHG] = st.dchg;
            nx.dout[rtc_pkg::ST_IFLAG] = st.iflag;
         end else if (st.s2.addr == rtc_pkg::A_HR_T) begin
            // (R2) (R3) Hour tens mask
            nx.dout = st.tm[rtc_pkg::A_HR_T] &
                      (st.setup[rtc_pkg::CS_MODE24] ? rtc_pkg::HT24_MASK : rtc_pkg::HT12_MASK);
         end else if (st.s2.addr == rtc_pkg::A_SETUP) begin
            // (R15) Full setup readback
            nx.dout = st.ctl[rtc_pkg::CTL_INT_SEL] ? st.irq : st.setup;
         end else begin
            // (R1) (R4) Plain digits
            nx.dout = st.tm[st.s2.addr];
         end
      end
      if (rs_fall) begin
         nx.ctl_rd = 1'b0;
         if (st.ctl_rd) begin
            // A timeout caught during the read lands now.
            nx.dchg = 1'b0;
            nx.iflag = st.ipend || tmo;
            nx.ipend = 1'b0;
         end
      end

      // ==========================================================
      // Write side
      if (commit) begin
         // (R10) Write decode
         if (a == rtc_pkg::A_CTRL) begin
            // (R22) Select and stop bits
            nx.ctl = d;
            if (d[rtc_pkg::CTL_CLK_STOP]) begin
               nx.tm[rtc_pkg::A_TENTH] = rtc_pkg::ZERO;
            end
         end else if (a == rtc_pkg::A_SETUP) begin
            if (st.ctl[rtc_pkg::CTL_INT_SEL]) begin
               nx.irq = d;
               // (R18) Code zero disables
               if (d[rtc_pkg::IR_CODE_W-1:0] == '0) begin
                  nx.ctl[rtc_pkg::CTL_INT_STOP] = 1'b1;
                  nx.iflag = 1'b0;
                  nx.ipend = 1'b0;
               end
            end else begin
               nx.setup = d;
               // (R3) PM forced in 24h
               if (d[rtc_pkg::CS_MODE24]) begin
                  nx.setup[rtc_pkg::CS_PM] = 1'b0;
               end
            end
         end else if (a != rtc_pkg::A_TENTH) begin
            // (R1) (R8) Digit write
            nx.tm[a] = d;
         end
      end
      nx.irq_n = !nx.iflag;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= rtc_pkg::ST_RST;
      end else if (ce) begin
         st <= nx;
      end
   end

   assign bus_data_lines_out = st.dout;
   assign bus_data_lines_oe = st.oe;
   assign irq_n = st.irq_n;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || !ce);

   sequence s_rd_sel;
      rs_rise && st.s2.addr == rtc_pkg::A_SETUP && st.ctl[rtc_pkg::CTL_INT_SEL];
   endsequence
   sequence s_rep_tmo;
      tmo && st.irq[rtc_pkg::IR_REPEAT] && !commit;
   endsequence

   property p_tenth_stop;
      st.ctl[rtc_pkg::CTL_CLK_STOP] |=> st.tm[rtc_pkg::A_TENTH] == rtc_pkg::ZERO;
   endproperty
   a_tenth_stop: assert property (p_tenth_stop) else $error("tenths not clear while stopped"); // R20

   property p_ht12;
      rs_rise && st.s2.addr == rtc_pkg::A_HR_T && !st.setup[rtc_pkg::CS_MODE24]
         |=> st.dout[3:1] == 3'h0;
   endproperty
   a_ht12: assert property (p_ht12) else $error("hour tens wider than one bit"); // R2

   property p_pm24;
      st.setup[rtc_pkg::CS_MODE24] |-> !st.setup[rtc_pkg::CS_PM];
   endproperty
   a_pm24: assert property (p_pm24) else $error("pm set in 24 hour mode"); // R3

   property p_code0;
      commit && st.wcap.addr == rtc_pkg::A_SETUP && st.ctl[rtc_pkg::CTL_INT_SEL] &&
      st.wcap.data[rtc_pkg::IR_CODE_W-1:0] == '0
         |=> st.ctl[rtc_pkg::CTL_INT_STOP] && st.irq_n ##1 st.irq_n;
   endproperty
   a_code0: assert property (p_code0) else $error("code zero left timer live"); // R18

   property p_single;
      tmo && !st.irq[rtc_pkg::IR_REPEAT] && !commit |=> st.ctl[rtc_pkg::CTL_INT_STOP];
   endproperty
   a_single: assert property (p_single) else $error("single mode kept running"); // R24

   property p_repeat;
      s_rep_tmo |=> !st.ctl[rtc_pkg::CTL_INT_STOP] && (st.iflag || st.ipend);
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeat mode stopped"); // R17

   property p_lock;
      s_rep_tmo ##1 !itick |-> st.icnt == '0;
   endproperty
   a_lock: assert property (p_lock) else $error("repeat count not restarted"); // R19

   property p_rd_sel;
      s_rd_sel |=> st.dout == $past(st.irq) && st.oe;
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("select bit ignored on read"); // R11

   property p_wday;
      day_roll && !commit && st.tm[rtc_pkg::A_WDAY] == rtc_pkg::WDAY_LAST
         |=> st.tm[rtc_pkg::A_WDAY] == rtc_pkg::FIRST;
   endproperty
   a_wday: assert property (p_wday) else $error("weekday did not wrap"); // R9

   property p_leap;
      mon_roll && !commit |=> st.setup[rtc_pkg::CS_LEAP_HI:rtc_pkg::CS_LEAP_LO] ==
         $past(st.setup[rtc_pkg::CS_LEAP_HI:rtc_pkg::CS_LEAP_LO]) + 2'h1;
   endproperty
   a_leap: assert property (p_leap) else $error("leap counter did not step"); // R12
endmodule
`default_nettype wire

// ---- bench/host_bus_model.sv ----
// Host processor model that drives the strobed register bus of the clock.
// Assumes the bench resolves the shared data wire and feeds it back here.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input wire logic sys_clk,
   input wire logic [3:0] bus_wire,
   input wire logic dev_oe,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [3:0] sel,
   output logic [3:0] host_data,
   output logic host_drive
);
   // ==========================================================
   // Idle bus
   // Released select lines go to their pull-up level, never the last value.
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      sel = 4'hF;
      host_data = 4'hF;
      host_drive = 1'b0;
   end
   // ==========================================================
   // Bus cycles
   task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      sel <= a;
      host_data <= d;
      host_drive <= 1'b1;
      repeat (4) @(posedge sys_clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      // Data outlives the strobe by a cycle so the trailing edge latches it.
      @(posedge sys_clk);
      sel <= 4'hF;
      host_drive <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [3:0] d);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      sel <= a;
      repeat (5) @(posedge sys_clk);
      d = (dev_oe === 1'b1) ? bus_wire : 4'hX;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      sel <= 4'hF;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// ---- bench/bcd_clock_calendar_with_interval_timer_bench.sv ----
// Self-checking bench for the BCD clock calendar and its interval timer.
// Assumes the host model owns the bus pins; the tick is shortened to TICK.
`timescale 1ns/1ps
`default_nettype none
module bcd_clock_calendar_with_interval_timer_bench;
   localparam int unsigned TICK = 16;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cs_n, rd_n, wr_n, host_drive, oe, irq_n;
   logic [3:0] sel, host_data, dout;
   wire logic [3:0] bus_wire;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   // The data lines have pull-ups, so an undriven bus reads all ones.
   assign bus_wire = oe ? dout : (host_drive ? host_data : 4'hF);
   always #4 sys_clk = ~sys_clk;
   rtc_core #(.TICK_CYCLES(TICK)) DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .register_select_lines(sel), .bus_data_lines_in(bus_wire),
      .bus_data_lines_out(dout), .bus_data_lines_oe(oe), .irq_n(irq_n));
   host_bus_model HOST (.sys_clk(sys_clk), .bus_wire(bus_wire), .dev_oe(oe), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .sel(sel), .host_data(host_data), .host_drive(host_drive));
   // ==========================================================
   // Timeout, sized for all seven interval periods run three times over
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         num_errors++;
         wrap_up();
      end
   end
   // ==========================================================
   // Helpers
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_n(input string what, input int exp, input int got);
      checks++;
      if (got != exp) begin
         num_errors++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      HOST.wr_reg(a, d);
   endtask
   task automatic rc(input logic [3:0] a, input logic [3:0] exp, input string what);
      logic [3:0] d;
      HOST.rd_reg(a, d);
      chk(what, exp, d);
   endtask
   task automatic wait_irq(input int lim, output int t);
      int n;
      n = 0;
      while (irq_n !== 1'b0 && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      chk_n("irq wait", 0, (n >= lim) ? 1 : 0);
      t = cyc;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_map();
      rc(rtc_pkg::A_CTRL, 4'h0, "status");
      rc(rtc_pkg::A_SETUP, 4'h0, "setup");
      wr(rtc_pkg::A_SEC_U, 4'h7);
      rc(rtc_pkg::A_SEC_U, 4'h7, "sec_u");
      wr(rtc_pkg::A_TENTH, 4'h9);
      rc(rtc_pkg::A_TENTH, 4'h0, "tenth");
      wr(rtc_pkg::A_YR_T, 4'h9);
      rc(rtc_pkg::A_YR_T, 4'h9, "yr_t");
      wr(rtc_pkg::A_HR_T, 4'hF);
      rc(rtc_pkg::A_HR_T, 4'h1, "hr_t 12h");
      wr(rtc_pkg::A_SETUP, 4'h1);
      rc(rtc_pkg::A_HR_T, 4'h3, "hr_t 24h");
      wr(rtc_pkg::A_HR_U, 4'hF);
      rc(rtc_pkg::A_HR_U, 4'hF, "hr_u");
      $display("test map done");
   endtask
   // Loads a time image with the clock stopped, runs a little over one
   // second and compares every digit; the hour mode and PM go separately.
   task automatic roll(input string name, input logic [63:0] img, input logic [3:0] s1,
                       input logic [3:0] s2, input logic [63:0] exp, input logic [3:0] exp_s);
      logic [15:0][3:0] a;
      logic [15:0][3:0] e;
      a = img;
      e = exp;
      wr(rtc_pkg::A_CTRL, 4'h5);
      wr(rtc_pkg::A_SETUP, s1);
      wr(rtc_pkg::A_SETUP, s2);
      for (int i = 2; i < 15; i++) begin
         wr(4'(i), a[i]);
      end
      wr(rtc_pkg::A_CTRL, 4'h3);
      repeat (14 * TICK) @(posedge sys_clk);
      wr(rtc_pkg::A_CTRL, 4'h5);
      rc(rtc_pkg::A_CTRL, 4'h8, "changed set");
      rc(rtc_pkg::A_CTRL, 4'h0, "changed clear");
      rc(rtc_pkg::A_TENTH, 4'h0, "tenth stop");
      for (int i = 2; i < 15; i++) begin
         rc(4'(i), e[i], $sformatf("%s location %0d", name, i));
      end
      rc(rtc_pkg::A_SETUP, exp_s, "setup");
      $display("test %s done", name);
   endtask
   task automatic t_periods();
      int per [7] = '{1, 5, 10, 50, 100, 300, 600};
      int t0;
      int t1;
      int ts;
      logic [3:0] d;
      wr(rtc_pkg::A_CTRL, 4'h7);
      for (int i = 0; i < 7; i++) begin
         wr(rtc_pkg::A_SETUP, {1'b1, 3'(i + 1)});
         wr(rtc_pkg::A_CTRL, 4'h6);
         ts = cyc;
         wait_irq(per[i] * TICK + 50, t0);
         // The start lands two cycles before wr returns; the line falls a cycle after the timeout.
         chk_n($sformatf("first timeout code %0d", i + 1), per[i] * TICK - 1, t0 - ts);
         rc(rtc_pkg::A_CTRL, 4'h1, "int flag");
         wait_irq(per[i] * TICK + 50, t0);
         HOST.rd_reg(rtc_pkg::A_CTRL, d);
         wait_irq(per[i] * TICK + 50, t1);
         chk_n($sformatf("period code %0d", i + 1), per[i] * TICK, t1 - t0);
         wr(rtc_pkg::A_CTRL, 4'h7);
         HOST.rd_reg(rtc_pkg::A_CTRL, d);
      end
      $display("test periods done");
   endtask
   task automatic t_single();
      int t;
      wr(rtc_pkg::A_SETUP, 4'h1);
      rc(rtc_pkg::A_SETUP, 4'h1, "interval reg");
      wr(rtc_pkg::A_CTRL, 4'h6);
      wait_irq(TICK + 50, t);
      rc(rtc_pkg::A_CTRL, 4'h1, "int flag");
      chk("irq_n cleared", 4'h1, {3'h0, irq_n});
      repeat (4 * TICK) @(posedge sys_clk);
      chk("irq_n single", 4'h1, {3'h0, irq_n});
      wr(rtc_pkg::A_CTRL, 4'h6);
      wait_irq(TICK + 50, t);
      wr(rtc_pkg::A_SETUP, 4'h0);
      chk("irq_n code zero", 4'h1, {3'h0, irq_n});
      wr(rtc_pkg::A_SETUP, 4'h9);
      repeat (4 * TICK) @(posedge sys_clk);
      chk("irq_n forced stop", 4'h1, {3'h0, irq_n});
      rc(rtc_pkg::A_CTRL, 4'h0, "flag after zero");
      $display("test single done");
   endtask
   // Holding the enable low must freeze the running interval timer.
   task automatic t_freeze();
      int t;
      wr(rtc_pkg::A_CTRL, 4'h6);
      @(posedge sys_clk);
      ce <= 1'b0;
      repeat (4 * TICK) @(posedge sys_clk);
      chk("irq_n frozen", 4'h1, {3'h0, irq_n});
      ce <= 1'b1;
      wait_irq(TICK + 50, t);
      wr(rtc_pkg::A_CTRL, 4'h7);
      rc(rtc_pkg::A_CTRL, 4'h1, "flag after freeze");
      $display("test freeze done");
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      t_map();
      roll("new year", 64'h0799_1231_2359_5900, 4'h1, 4'hD, 64'h0100_0101_0000_0000, 4'h1);
      roll("leap feb", 64'h0224_0228_2359_5900, 4'h1, 4'h1, 64'h0324_0229_0000_0000, 4'h1);
      roll("plain feb", 64'h0224_0228_2359_5900, 4'h1, 4'h5, 64'h0324_0301_0000_0000, 4'h5);
      roll("april", 64'h0324_0430_2359_5900, 4'h1, 4'h1, 64'h0424_0501_0000_0000, 4'h1);
      roll("noon", 64'h0342_0615_1159_5900, 4'h0, 4'h0, 64'h0342_0615_1200_0000, 4'h2);
      roll("midnight", 64'h0524_0731_1159_5900, 4'h0, 4'h2, 64'h0624_0801_1200_0000, 4'h0);
      t_periods();
      t_single();
      t_freeze();
      wrap_up();
   end
endmodule
`default_nettype wire
